// ===== src/tcap_host.sv
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module tcap_host #(
  parameter int BCLK_HALF = tcap_pkg::BCLK_HALF_CYC,
  parameter int FRAME_BITS = tcap_pkg::FRAME_BITS_DEF,
  parameter int AUDIO_SLOTS = tcap_pkg::AUDIO_SLOTS_DEF,
  parameter int SAMPLE_W = tcap_pkg::SAMPLE_W_DEF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic bit_clock_o,
  output logic frame_sync_o,
  output logic serial_data_in_o,
  input wire logic ctrl_data_out_i
);
  localparam int PW = $clog2(FRAME_BITS);
  localparam logic [PW-1:0] POS_LAST = PW'(FRAME_BITS - 1);
  localparam logic [PW-1:0] POS_HALF = PW'(FRAME_BITS / 2);
  localparam logic [PW-1:0] POS_MUX = PW'(tcap_pkg::MUX_SYNC_BITS);
  localparam logic [PW-1:0] POS_RD_FIRST = PW'(31 - tcap_pkg::DATA_HI);
  localparam logic [PW-1:0] POS_RD_LAST = PW'(31 - tcap_pkg::DATA_LO);
  localparam logic [PW-1:0] POS_CHAIN = PW'(31 - tcap_pkg::CHAIN_SEL_BIT);
  localparam int FILL = 32 - SAMPLE_W;

  // refuse geometries the frame builder cannot serve
  if (BCLK_HALF < tcap_pkg::BCLK_MIN_HALF_CYC) begin : g_chk_bclk
    $error("bit clock faster than the link allows");
  end
  if (FRAME_BITS != (1 << PW) || FRAME_BITS < 64 ||
      FRAME_BITS < tcap_pkg::SLOT_BITS * (AUDIO_SLOTS + 1)) begin : g_chk_frame
    $error("frame length must be a power of two holding all slots");
  end
  if (SAMPLE_W < 1 || SAMPLE_W > 32 || AUDIO_SLOTS < 1) begin : g_chk_audio
    $error("unsupported audio slot shape");
  end

  logic bclk;
  logic rise_en;
  logic fall_en;
  logic sdo_sync;
  logic [1:0] ctrl_reg;
  logic [30:8] cmd_reg;
  logic [28:8] ext_reg;
  logic [SAMPLE_W-1:0] aud_reg [AUDIO_SLOTS];
  logic cmd_pend_reg;
  logic id_pend_reg;
  logic [PW-1:0] pos_reg;
  logic frame_on_reg;
  logic ext_frame_reg;
  logic rd_frame_reg;
  logic [31:0] cmd_word_reg;
  logic [31:0] ext_word_reg;
  logic [7:0] rd_shift_reg;
  logic rd_valid_reg;
  logic [PW-1:0] pos_next;
  logic [31:0] word_next;
  logic [4:0] bit_next;
  logic frame_edge;
  logic in_aud;
  logic [7:0] aud_off;
  int aud_idx;

  // bit clock is made here; the device sees it as its link clock
  tcap_bclk_div #(
    .HALF(BCLK_HALF)
  ) u_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .bclk_o(bclk),
    .rise_o(rise_en),
    .fall_o(fall_en)
  );

  // no chain pins here: the host ignores that handshake
  // device's three-state read-back pin arrives asynchronously
  tcap_sync2 #(
    .W(1)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(ctrl_data_out_i),
    .q_o(sdo_sync)
  );

  // audio register decode
  assign aud_off = addr_i - tcap_pkg::REG_AUD_BASE;
  assign in_aud = (addr_i >= tcap_pkg::REG_AUD_BASE) && (addr_i[1:0] == 2'h0) &&
                  ({2'h0, aud_off[7:2]} < 8'(AUDIO_SLOTS));
  assign aud_idx = int'(aud_off[7:2]);

  // software-written control, command and sample registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= tcap_pkg::CTRL_RESET;
      cmd_reg <= '0;
      ext_reg <= '0;
      for (int i = 0; i < AUDIO_SLOTS; i++) begin
        aud_reg[i] <= '0;
      end
    end else if (wr_i) begin
      if (addr_i == tcap_pkg::REG_CTRL) begin
        ctrl_reg <= wdata_i[1:0];
      end
      if (addr_i == tcap_pkg::REG_CMD) begin
        // ids above thirty are left to software
        cmd_reg <= wdata_i[30:8];
      end
      if (addr_i == tcap_pkg::REG_EXT) begin
        ext_reg <= wdata_i[28:8];
      end
      if (in_aud) begin
        aud_reg[aud_idx] <= wdata_i[SAMPLE_W-1:0];
      end
    end
  end

  // command and extended words are frozen on the last rising edge of the frame; samples are read live
  assign frame_edge = rise_en && (pos_reg == POS_LAST);

  // pending flags; a new request beats the frame that consumes the old one
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cmd_pend_reg <= 1'b0;
      id_pend_reg <= 1'b0;
    end else begin
      if (frame_edge && ctrl_reg[tcap_pkg::CTRL_RUN]) begin
        if (id_pend_reg) begin
          id_pend_reg <= 1'b0;
        end else begin
          cmd_pend_reg <= 1'b0;
        end
      end
      if (wr_i && addr_i == tcap_pkg::REG_CMD) begin
        cmd_pend_reg <= 1'b1;
      end
      if (wr_i && addr_i == tcap_pkg::REG_CTRL && wdata_i[tcap_pkg::CTRL_ID_REQ]) begin
        id_pend_reg <= 1'b1;
      end
    end
  end

  // build command and extended words for the coming frame
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      frame_on_reg <= 1'b0;
      ext_frame_reg <= 1'b0;
      rd_frame_reg <= 1'b0;
      cmd_word_reg <= '0;
      ext_word_reg <= '0;
    end else if (frame_edge) begin
      frame_on_reg <= ctrl_reg[tcap_pkg::CTRL_RUN];
      ext_frame_reg <= 1'b0;
      rd_frame_reg <= 1'b0;
      cmd_word_reg <= '0; // id 0 when idle: nobody answers
      ext_word_reg <= {3'h0, ext_reg, 8'h00}; // no id flag
      if (id_pend_reg) begin
        // id assignment frame; rest of field left zero
        cmd_word_reg[tcap_pkg::ID_ASSIGN_BIT] <= 1'b1;
      end else if (cmd_pend_reg) begin
        // chain select forced low for the input chain
        cmd_word_reg <= {1'b0, cmd_reg[30], 1'b0, cmd_reg[28:8], 8'h00};
        ext_frame_reg <= cmd_reg[tcap_pkg::EXT_BIT];
        rd_frame_reg <= cmd_reg[tcap_pkg::RW_BIT];
      end
    end
  end

  // serial position of the bit that goes out next
  assign pos_next = (pos_reg == POS_LAST) ? '0 : pos_reg + 1'b1;
  assign bit_next = 5'd31 - pos_next[4:0];

  // slot word: command first, then extended packet or audio
  always_comb begin
    word_next = '0;
    if (pos_next[PW-1:5] == '0) begin
      word_next = cmd_word_reg;
    end else if (ext_frame_reg) begin
      if (pos_next[PW-1:5] == 1) begin
        word_next = ext_word_reg; // audio suppressed
      end
    end else if (int'(pos_next[PW-1:5]) <= AUDIO_SLOTS) begin
      // left-justified sample with zero fill
      word_next = 32'(aud_reg[int'(pos_next[PW-1:5]) - 1]) << FILL;
    end
  end

  // position counter and pins change only after a falling edge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pos_reg <= POS_LAST;
      serial_data_in_o <= 1'b0;
      frame_sync_o <= 1'b0;
    end else if (fall_en) begin
      pos_reg <= pos_next;
      serial_data_in_o <= frame_on_reg && word_next[bit_next];
      if (!frame_on_reg) begin
        frame_sync_o <= 1'b0;
      end else if (ctrl_reg[tcap_pkg::CTRL_MUX]) begin
        frame_sync_o <= pos_next < POS_MUX; // two-bit pulse selects mode
      end else begin
        frame_sync_o <= pos_next < POS_HALF;
      end
    end
  end

  // bit clock pin straight from the divider flop timing, one cycle later
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bit_clock_o <= 1'b0;
    end else begin
      bit_clock_o <= bclk;
    end
  end

  // read-back captured on rising edges during the data byte
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_shift_reg <= '0;
    end else if (rise_en && frame_on_reg && rd_frame_reg &&
                 pos_reg >= POS_RD_FIRST && pos_reg <= POS_RD_LAST) begin
      rd_shift_reg <= {rd_shift_reg[6:0], sdo_sync}; // msb first
    end
  end

  // read valid: set on the last data bit, cleared by a new command; set wins
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_valid_reg <= 1'b0;
    end else if (rise_en && frame_on_reg && rd_frame_reg && pos_reg == POS_RD_LAST) begin
      rd_valid_reg <= 1'b1;
    end else if (wr_i && addr_i == tcap_pkg::REG_CMD) begin
      rd_valid_reg <= 1'b0;
    end
  end

  // read port: data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= '0;
      if (addr_i == tcap_pkg::REG_CTRL) begin
        rdata_o[1:0] <= ctrl_reg;
      end else if (addr_i == tcap_pkg::REG_CMD) begin
        rdata_o[30:8] <= cmd_reg;
      end else if (addr_i == tcap_pkg::REG_EXT) begin
        rdata_o[28:8] <= ext_reg;
      end else if (addr_i == tcap_pkg::REG_STAT) begin
        rdata_o[tcap_pkg::STAT_CMD_PEND] <= cmd_pend_reg;
        rdata_o[tcap_pkg::STAT_ID_PEND] <= id_pend_reg;
        rdata_o[tcap_pkg::STAT_RD_VALID] <= rd_valid_reg;
        rdata_o[tcap_pkg::STAT_RD_LO +: 8] <= rd_shift_reg;
      end else if (in_aud) begin
        rdata_o[SAMPLE_W-1:0] <= aud_reg[aud_idx];
      end
    end
  end

  // chain select bit is never high on the wire
  property p_chain_low;
    @(posedge clk_i) disable iff (!resetn_i)
    (pos_reg == POS_CHAIN) |-> !serial_data_in_o;
  endproperty
  a_chain_low: assert property (p_chain_low) else $error("chain select driven high");

  // nothing but zeros past the extended packet
  property p_ext_no_audio;
    @(posedge clk_i) disable iff (!resetn_i)
    (ext_frame_reg && pos_reg[PW-1:5] >= 2) |-> !serial_data_in_o;
  endproperty
  a_ext_no_audio: assert property (p_ext_no_audio) else $error("audio in extended frame");

  // zero fill below each sample
  property p_aud_fill;
    @(posedge clk_i) disable iff (!resetn_i)
    (!ext_frame_reg && pos_reg[PW-1:5] != '0 && int'(pos_reg[4:0]) >= SAMPLE_W)
      |-> !serial_data_in_o;
  endproperty
  a_aud_fill: assert property (p_aud_fill) else $error("audio fill bit not zero");

  // data and sync move only just after a falling bit clock edge
  property p_data_on_fall;
    @(posedge clk_i) disable iff (!resetn_i)
    $changed(serial_data_in_o) |-> $past(fall_en);
  endproperty
  a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off fall");

  property p_sync_on_fall;
    @(posedge clk_i) disable iff (!resetn_i)
    $changed(frame_sync_o) |-> $past(fall_en) && !bit_clock_o;
  endproperty
  a_sync_on_fall: assert property (p_sync_on_fall) else $error("sync moved off fall");

  // a frame opens at position zero with the command field
  property p_frame_start;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(frame_sync_o) |-> pos_reg == '0;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame not at slot 0");

  // low byte of the command slot stays zero
  property p_low_byte;
    @(posedge clk_i) disable iff (!resetn_i)
    (pos_reg > POS_RD_LAST && pos_reg[PW-1:5] == '0) |-> !serial_data_in_o;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte driven");

  // read completion only for a frame that sent a read bit
  property p_read_valid;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(rd_valid_reg) |-> rd_frame_reg && cmd_word_reg[tcap_pkg::RW_BIT] &&
      $past(pos_reg) == POS_RD_LAST;
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read valid without read");
endmodule

// ===== src/tcap_pkg.sv
package tcap_pkg;
  // system clock and bit clock timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BCLK_MIN_PERIOD_NS = 20;
  localparam int BCLK_PERIOD_NS = 80;
  localparam int BCLK_HALF_CYC = (BCLK_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
  localparam int BCLK_MIN_HALF_CYC =
    (BCLK_MIN_PERIOD_NS * 1000 + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);

  // frame geometry
  localparam int SLOT_BITS = 32;
  localparam int FRAME_BITS_DEF = 128;
  localparam int AUDIO_SLOTS_DEF = 2;
  localparam int SAMPLE_W_DEF = 24;
  localparam int MUX_SYNC_BITS = 2;

  // command field layout
  localparam int ID_ASSIGN_BIT = 31;
  localparam int EXT_BIT = 30;
  localparam int CHAIN_SEL_BIT = 29;
  localparam int DEV_ID_HI = 28;
  localparam int DEV_ID_LO = 24;
  localparam int RW_BIT = 23;
  localparam int DATA_HI = 15;
  localparam int DATA_LO = 8;
  localparam logic [4:0] DEV_ID_NONE = 5'h00;
  localparam logic [4:0] DEV_ID_BCAST = 5'h1F;

  // software register map of the controller
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_EXT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_AUD_BASE = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MUX = 1;
  localparam int CTRL_ID_REQ = 2;
  localparam int STAT_CMD_PEND = 0;
  localparam int STAT_ID_PEND = 1;
  localparam int STAT_RD_VALID = 2;
  localparam int STAT_RD_LO = 8;
  localparam logic [1:0] CTRL_RESET = 2'h0;
endpackage

// ===== src/tcap_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module tcap_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// ===== src/tcap_bclk_div.sv
`timescale 1ns/1ps
// bit clock divider with edge enables
module tcap_bclk_div #(
  parameter int HALF = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  output logic bclk_o,
  output logic rise_o,
  output logic fall_o
);
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_reg;

  // rise/fall pulse in the same cycle the clock flop changes
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
      bclk_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (cnt_reg == LAST) begin
        cnt_reg <= '0;
        bclk_o <= !bclk_o;
        rise_o <= !bclk_o;
        fall_o <= bclk_o;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// ===== dv/tcap_dev_model.sv
`timescale 1ns/1ps
// behavioural input-chain converter at the far end of the link
module tcap_dev_model #(
  parameter int AUDIO_SLOTS = 2
) (
  input wire logic bit_clock_i,
  input wire logic frame_sync_i,
  input wire logic serial_data_in_i,
  input wire logic chain_in_i,
  output logic chain_out_o,
  output logic ctrl_data_out_o
);
  initial ctrl_data_out_o = 1'b0;
  logic [7:0] regs [128] = '{default: 8'h00};
  logic [31:0] audio_word [AUDIO_SLOTS] = '{default: 32'h0};
  logic [31:0] sh = 32'h0;
  logic [31:0] ext_word = 32'h0;
  logic [7:0] rd_byte = 8'h00;
  logic [4:0] my_id = 5'h00;
  logic sync_q = 1'b0;
  logic ext_frame = 1'b0;
  logic mux_mode = 1'b0;
  logic sel_rd = 1'b0;
  logic ext_tail = 1'b0;
  int pos = 999;
  int sync_len = 0;
  int mux_frames = 0;

  // sample on the rising bit clock; commands only count once short syncs are seen
  always @(posedge bit_clock_i) begin
    if (frame_sync_i && !sync_q) begin
      mux_frames = (sync_len == 2) ? mux_frames + 1 : 0;
      mux_mode = (mux_frames >= 2);
      sync_len = 0;
      pos = 0;
      ext_frame = 1'b0;
    end else begin
      pos = pos + 1;
    end
    sync_len = sync_len + int'(frame_sync_i);
    sync_q = frame_sync_i;
    sh = {sh[30:0], serial_data_in_i};
    // read select must be known before the early enable
    if (pos == 14)
      sel_rd = mux_mode && !sh[14] && !sh[12] && sh[6] && sh[11:7] == my_id && my_id != 5'h00;
    if (pos == 15 && sel_rd)
      rd_byte = regs[sh[6:0]];
    if (pos == 31 && mux_mode) begin
      if (sh[31]) begin
        // id frame: rest of the word ignored; only top of chain supported here
        if (chain_in_i)
          my_id = 5'h01;
        regs[23] = {3'h0, my_id};
      end else begin
        ext_frame = sh[30];
        if (!sh[29] && !sh[23] && sh[28:24] != 5'h00 && (sh[28:24] == my_id || sh[28:24] == 5'h1F))
          regs[sh[22:16]] = sh[15:8];
      end
    end
    if (ext_frame && pos == 63)
      ext_word = sh;
    if (ext_frame && pos > 63 && serial_data_in_i)
      ext_tail = 1'b1;
    if (!ext_frame && pos % 32 == 31 && pos > 31 && pos < 32 * (AUDIO_SLOTS + 1))
      audio_word[pos / 32 - 1] = sh;
  end

  // drive on the falling edge; a released line toggles so no stale level survives
  always @(negedge bit_clock_i) begin
    if (sel_rd && pos >= 14 && pos <= 22)
      ctrl_data_out_o <= (pos == 14) ? 1'b0 : rd_byte[22 - pos];
    else
      ctrl_data_out_o <= ~ctrl_data_out_o;
  end

  // chain out marks our last audio slot; with no slots chain in passes through
  assign chain_out_o = (AUDIO_SLOTS == 0) ? chain_in_i :
    (mux_mode && !ext_frame && pos / 32 == AUDIO_SLOTS);
endmodule

// ===== dv/tdm_command_audio_in_port_test.sv
`timescale 1ns/1ps
// host controller driving one modelled converter over the link
module tdm_command_audio_in_port_test;
  localparam int FRAME_CLK = tcap_pkg::FRAME_BITS_DEF * 2 * tcap_pkg::BCLK_HALF_CYC + 40;
  logic clk_i;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic bit_clock, frame_sync, serial_data, data_back;
  logic [31:0] val;
  int num_errors = 0;
  int samples_checked = 0;

  tcap_host dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_clock_o(bit_clock),
    .frame_sync_o(frame_sync), .serial_data_in_o(serial_data), .ctrl_data_out_i(data_back));

  // chain in tied high: this device is the top of the input chain
  tcap_dev_model dev (.bit_clock_i(bit_clock), .frame_sync_i(frame_sync),
    .serial_data_in_i(serial_data), .chain_in_i(1'b1), .chain_out_o(),
    .ctrl_data_out_o(data_back));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // one strobe cycle then one idle cycle, so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // poll a pending flag until it drops, then let that frame run out
  task automatic wait_clear(input int b);
    logic [31:0] s = 32'hFFFF_FFFF;
    for (int n = 0; n < 2000 && s[b] !== 1'b0; n++)
      rd(tcap_pkg::REG_STAT, s);
    check({31'h0, s[b]}, 32'h0);
    repeat (FRAME_CLK) @(posedge clk_i);
  endtask

  task automatic cmd(input logic [31:0] w);
    wr(tcap_pkg::REG_CMD, w);
    wait_clear(tcap_pkg::STAT_CMD_PEND);
  endtask

  function automatic logic [31:0] word(input logic ext, input logic [4:0] id, input logic rw,
      input logic [6:0] rg, input logic [7:0] d);
    return {1'b0, ext, 1'b0, id, rw, rg, d, 8'h00};
  endfunction

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_i);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd(tcap_pkg::REG_CTRL, val);
    check(val, 32'h0);
    rd(8'h40, val);
    check(val, 32'h0);
    wr(tcap_pkg::REG_CTRL, 32'h3);
    rd(tcap_pkg::REG_CTRL, val);
    check(val, 32'h3);
    // the device needs two short-sync frames before it takes commands
    repeat (4 * FRAME_CLK) @(posedge clk_i);
    wr(tcap_pkg::REG_CTRL, 32'h7);
    wait_clear(tcap_pkg::STAT_ID_PEND);
    check({27'h0, dev.my_id}, 32'h1);
    cmd(word(1'b0, 5'h01, 1'b0, 7'h13, 8'hA5));
    check({24'h0, dev.regs[8'h13]}, 32'hA5);
    cmd(word(1'b0, 5'h1F, 1'b0, 7'h05, 8'h3C));
    check({24'h0, dev.regs[5]}, 32'h3C);
    cmd(word(1'b0, 5'h02, 1'b0, 7'h06, 8'h11));
    check({24'h0, dev.regs[6]}, 32'h0);
    cmd(word(1'b0, 5'h00, 1'b0, 7'h07, 8'h22));
    check({24'h0, dev.regs[7]}, 32'h0);
    cmd(word(1'b0, 5'h01, 1'b0, 7'h08, 8'h77) | 32'h2000_0000);
    check({24'h0, dev.regs[8]}, 32'h77);
    cmd(word(1'b0, 5'h01, 1'b1, 7'h13, 8'h00));
    rd(tcap_pkg::REG_STAT, val);
    check(val, 32'h0000_A504);
    cmd(word(1'b0, 5'h01, 1'b1, 7'd23, 8'h00));
    rd(tcap_pkg::REG_STAT, val);
    check(val, 32'h0000_0104);
    rd(tcap_pkg::REG_CMD, val);
    check(val, 32'h0197_0000);
    // audio left in place so an extended frame would show any leak
    wr(tcap_pkg::REG_AUD_BASE, 32'h0012_3456);
    wr(tcap_pkg::REG_AUD_BASE + 8'h04, 32'h00AB_CDEF);
    repeat (2 * FRAME_CLK) @(posedge clk_i);
    check(dev.audio_word[0], 32'h1234_5600);
    check(dev.audio_word[1], 32'hABCD_EF00);
    rd(tcap_pkg::REG_AUD_BASE, val);
    check(val, 32'h0012_3456);
    wr(tcap_pkg::REG_EXT, 32'hF234_5600);
    rd(tcap_pkg::REG_EXT, val);
    check(val, 32'h1234_5600);
    cmd(word(1'b1, 5'h01, 1'b0, 7'h09, 8'h5A));
    check(dev.ext_word, 32'h1234_5600);
    check({31'h0, dev.ext_tail}, 32'h0);
    check({24'h0, dev.regs[9]}, 32'h5A);
    conclude();
  end
endmodule
